// ---- verilog/scg_pkg.sv ----
// Operation
// - Master clock high and low each last at least one system clock.
// - Slave drives its output within four clocks of select falling.
// - Slave floats its output within four clocks of select rising.
// - Slave output changes within four clocks of a shifting edge.
// - Phase one slave output changes six to eight clocks after end.
// - Polarity select one inverts idle and active clock levels.
`default_nettype none
package scg_pkg;
  // Core clock
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  // Slave timing, in system clock periods
  localparam int unsigned T_SEZ_MAX_PER = 4;
  localparam int unsigned T_SLH_MIN_PER = 6;
  localparam int unsigned T_SLH_MAX_PER = 8;
  localparam int unsigned SYNC_STAGES = 2;
  // Wait after the last edge is seen, landing inside the window
  localparam logic [2:0] POST_WAIT =
    3'(T_SLH_MIN_PER - SYNC_STAGES);
  // Edges of one byte
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'hA0;
  localparam logic [7:0] IDX_STATUS = 8'hA1;
  localparam logic [7:0] IDX_DIV = 8'hA2;
  localparam logic [7:0] IDX_DATA = 8'hA3;
  localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_DIV = {2'h0, IDX_DIV, 2'h0};
  localparam logic [11:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
  // Field positions and reset values
  localparam int unsigned CTRL_MASTER = 0;
  localparam int unsigned CTRL_CPOL = 1;
  localparam int unsigned CTRL_CPHA = 2;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_SEL = 2;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] TX_RESET = 8'h00;
  // Register bus request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } scg_apb_req_type;
  // Master and slave sequencers
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_RUN = 2'b01
  } scg_mst_type;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ACTIVE = 2'b01,
    S_POST = 2'b10
  } scg_slv_type;
  // Core state
  typedef struct packed {
    logic [7:0] div;
    logic master;
    logic cpol;
    logic cpha;
    logic [7:0] tx;
    logic [7:0] rx;
    logic done;
    scg_mst_type mst;
    logic [7:0] hcnt;
    logic [3:0] edge_n;
    logic sck;
    logic [7:0] msh;
    logic [7:0] mrx;
    scg_slv_type slv;
    logic [4:0] sedge;
    logic [7:0] ssh;
    logic oe;
    logic [2:0] post;
    logic sck_q;
    logic nss_q;
    logic tog_q;
    logic [31:0] prdata;
  } scg_core_type;
  // Link side state
  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] shift;
  } scg_frame_type;
  typedef struct packed {
    logic [7:0] data;
    logic tog;
  } scg_hold_type;
endpackage : scg_pkg
`default_nettype wire

// ---- verilog/scg_sync.sv ----
`default_nettype none
module scg_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Levels
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scg_sync_type;
  scg_sync_type st;
  scg_sync_type next_st;

  if (W < 1) begin : g_chk
    $error("scg_sync needs a width of at least one");
  end

  // First stage feeds only the second
  always_comb begin
    next_st.s1 = i_d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= {RST, RST};
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.s2;
endmodule : scg_sync
`default_nettype wire

// ---- verilog/scg_slave_rx.sv ----
`default_nettype none
module scg_slave_rx
  import scg_pkg::*;
(
  // Link clock and resets
  input wire logic i_link_sck,
  input wire logic i_nrst,
  input wire logic i_nss_n,
  // Quasi-static configuration
  input wire logic i_master,
  input wire logic i_cpol,
  input wire logic i_cpha,
  // Serial data in
  input wire logic i_mosi,
  // Received byte and its event toggle
  output logic [7:0] o_byte,
  output logic o_tog
);
  scg_frame_type fr;
  scg_frame_type next_fr;
  scg_hold_type hd;
  scg_hold_type next_hd;
  logic smp_clk;
  logic frame_rst;

  // Rising edge of this clock is always the sampling edge
  assign smp_clk = i_link_sck ^ i_cpol ^ i_cpha;
  // Clock stands still between frames, so select clears the count
  assign frame_rst = !i_nrst || i_nss_n || i_master;

  // Shift in and flag a whole byte
  always_comb begin
    next_fr.shift = {fr.shift[6:0], i_mosi};
    next_fr.cnt = fr.cnt + 3'h1;
    next_hd = hd;
    if (fr.cnt == LAST_BIT) begin
      next_hd.data = next_fr.shift;
      next_hd.tog = !hd.tog;
    end
  end

  always_ff @(posedge smp_clk or posedge frame_rst) begin
    if (frame_rst) begin
      fr <= '0;
    end else begin
      fr <= next_fr;
    end
  end

  // Held byte survives the end of the frame
  always_ff @(posedge smp_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hd <= '0;
    end else begin
      hd <= next_hd;
    end
  end

  assign o_byte = hd.data;
  assign o_tog = hd.tog;
endmodule : scg_slave_rx
`default_nettype wire

// ---- verilog/scg_top.sv ----
`default_nettype none
module scg_top
  import scg_pkg::*;
(
  // Clocks and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_link_sck,
  // Register bus
  input wire scg_apb_req_type i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial clock pin, master drive
  output logic o_sck,
  output logic o_sck_oe,
  // Master data out pin
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_mosi,
  // Slave data out pin
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_miso,
  // Slave select pin
  input wire logic i_nss_n
);
  scg_core_type st;
  scg_core_type next_st;
  logic [2:0] pins;
  logic rx_tog;
  logic rx_tog_s;
  logic [7:0] rx_byte;
  logic sck_norm;
  logic rise;
  logic fall;
  logic nss_fall;
  logic nss_rise;
  logic shift_ev;
  logic post_fire;
  logic setup;
  logic access;
  logic mapped;
  logic wr;
  logic sample;
  logic shift;

  // Clock, select and slave data pins cross two flops first
  scg_sync #(
    .W(3),
    .RST(3'h2)
  ) u_pin_sync (
    .i_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_d({i_link_sck, i_nss_n, i_miso}),
    .o_q(pins)
  );

  // Receive path on the link clock
  scg_slave_rx u_rx (
    .i_link_sck(i_link_sck),
    .i_nrst(i_nrst),
    .i_nss_n(i_nss_n),
    .i_master(st.master),
    .i_cpol(st.cpol),
    .i_cpha(st.cpha),
    .i_mosi(i_mosi),
    .o_byte(rx_byte),
    .o_tog(rx_tog)
  );

  // Byte event crosses as a toggle; data is stable for a whole byte
  scg_sync #(
    .W(1),
    .RST(1'h0)
  ) u_tog_sync (
    .i_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_d(rx_tog),
    .o_q(rx_tog_s)
  );

  // Bus decode
  assign setup = i_apb.psel && !i_apb.penable;
  assign access = i_apb.psel && i_apb.penable;
  assign mapped = i_apb.paddr == ADDR_CTRL ||
    i_apb.paddr == ADDR_STATUS || i_apb.paddr == ADDR_DIV ||
    i_apb.paddr == ADDR_DATA;
  assign wr = access && i_apb.pwrite && mapped;

  // Slave edge detection on the synchronised pins
  assign sck_norm = pins[2] ^ st.cpol;
  assign rise = sck_norm && !st.sck_q;
  assign fall = !sck_norm && st.sck_q;
  assign nss_fall = !pins[1] && st.nss_q;
  assign nss_rise = pins[1] && !st.nss_q;
  assign shift_ev = st.slv == S_ACTIVE &&
    (st.cpha ? (rise && st.sedge != 5'h0) : fall);
  assign post_fire = st.slv == S_POST && st.post == POST_WAIT - 3'h1;

  // Master edge kind from edge parity and phase
  assign sample = st.edge_n[0] == st.cpha;
  assign shift = !sample && !(st.cpha && st.edge_n == 4'h0);

  always_comb begin
    next_st = st;
    next_st.sck_q = sck_norm;
    next_st.nss_q = pins[1];
    next_st.tog_q = rx_tog_s;

    // Registers
    if (wr && i_apb.paddr == ADDR_CTRL) begin
      next_st.master = i_apb.pwdata[CTRL_MASTER];
      next_st.cpol = i_apb.pwdata[CTRL_CPOL];
      next_st.cpha = i_apb.pwdata[CTRL_CPHA];
    end
    if (wr && i_apb.paddr == ADDR_DIV) begin
      next_st.div = i_apb.pwdata[7:0];
    end
    if (wr && i_apb.paddr == ADDR_STATUS &&
        i_apb.pwdata[STAT_DONE]) begin
      next_st.done = 1'b0;
    end
    if (wr && i_apb.paddr == ADDR_DATA) begin
      next_st.tx = i_apb.pwdata[7:0];
    end

    // Master sequencer
    case (st.mst)
      M_IDLE: begin
        next_st.sck = 1'b0;
        if (wr && i_apb.paddr == ADDR_DATA && st.master) begin
          next_st.msh = i_apb.pwdata[7:0];
          next_st.hcnt = 8'h00;
          next_st.edge_n = 4'h0;
          next_st.mst = M_RUN;
        end
      end
      M_RUN: begin
        // Half period of divider plus one, never under one clock
        if (st.hcnt >= st.div) begin
          next_st.hcnt = 8'h00;
          next_st.sck = !st.sck;
          next_st.edge_n = st.edge_n + 4'h1;
          if (sample) begin
            next_st.mrx = {st.mrx[6:0], pins[0]};
          end
          if (shift) begin
            next_st.msh = {st.msh[6:0], 1'b0};
          end
          if (st.edge_n == LAST_EDGE) begin
            next_st.rx = next_st.mrx;
            next_st.done = 1'b1;
            next_st.mst = M_IDLE;
          end
        end else begin
          next_st.hcnt = st.hcnt + 8'h01;
        end
        if (!st.master) begin
          next_st.mst = M_IDLE;
        end
      end
      default: begin
        next_st.mst = M_IDLE;
      end
    endcase

    // Slave output sequencer
    case (st.slv)
      S_IDLE: begin
        next_st.oe = 1'b0;
        if (nss_fall && !st.master) begin
          next_st.ssh = st.tx;
          next_st.sedge = 5'h00;
          next_st.oe = 1'b1;
          next_st.slv = S_ACTIVE;
        end
      end
      S_ACTIVE: begin
        if (rise || fall) begin
          next_st.sedge = st.sedge + 5'h01;
        end
        if (shift_ev) begin
          next_st.ssh = {st.ssh[6:0], 1'b0};
        end
        if ((rise || fall) && st.sedge == EDGES_PER_BYTE - 5'h01) begin
          next_st.sedge = 5'h00;
          if (st.cpha) begin
            next_st.post = 3'h0;
            next_st.slv = S_POST;
          end else begin
            next_st.ssh = st.tx;
          end
        end
      end
      S_POST: begin
        // Edges seen here are lost; the remote clock is slower
        next_st.post = st.post + 3'h1;
        if (post_fire) begin
          next_st.ssh = st.tx;
          next_st.slv = S_ACTIVE;
        end
      end
      default: begin
        next_st.slv = S_IDLE;
      end
    endcase
    if (st.slv != S_IDLE && (nss_rise || st.master)) begin
      next_st.oe = 1'b0;
      next_st.slv = S_IDLE;
    end

    // Received slave byte, set wins over clear
    if (rx_tog_s != st.tog_q) begin
      next_st.rx = rx_byte;
      next_st.done = 1'b1;
    end

    // Read data taken in the setup phase
    next_st.prdata = 32'h0000_0000;
    if (setup) begin
      case (i_apb.paddr)
        ADDR_CTRL: begin
          next_st.prdata[CTRL_MASTER] = st.master;
          next_st.prdata[CTRL_CPOL] = st.cpol;
          next_st.prdata[CTRL_CPHA] = st.cpha;
        end
        ADDR_STATUS: begin
          next_st.prdata[STAT_BUSY] = st.mst == M_RUN;
          next_st.prdata[STAT_DONE] = st.done;
          next_st.prdata[STAT_SEL] = st.slv != S_IDLE;
        end
        ADDR_DIV: begin
          next_st.prdata[7:0] = st.div;
        end
        ADDR_DATA: begin
          next_st.prdata[7:0] = st.rx;
        end
        default: begin
          next_st.prdata = 32'h0000_0000;
        end
      endcase
    end else begin
      next_st.prdata = st.prdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
      st.div <= DIV_RESET;
      st.tx <= TX_RESET;
      st.nss_q <= 1'b1;
      st.mst <= M_IDLE;
      st.slv <= S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Bus answers one cycle after setup
  assign o_prdata = st.prdata;
  assign o_pready = access;
  assign o_pslverr = access && !mapped;

  // Pins; the clock idles at the polarity level
  assign o_sck = st.sck ^ st.cpol;
  assign o_sck_oe = st.master;
  assign o_mosi = st.msh[7];
  assign o_mosi_oe = st.master;
  assign o_miso = st.ssh[7];
  assign o_miso_oe = st.oe;

  // Helper: cycles since the clock pin last moved
  logic [7:0] hp;
  logic sck_d;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hp <= 8'h00;
      sck_d <= 1'b0;
    end else begin
      sck_d <= o_sck;
      hp <= (o_sck != sck_d) ? 8'h00 : hp + 8'h01;
    end
  end

  a_half_period: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st.mst == M_RUN && st.edge_n > 4'h1 && o_sck != sck_d &&
     $stable(st.div)) |-> hp == st.div)
    else $error("serial clock half period differs from divider");

  a_phase_min: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st.mst == M_RUN && $changed(o_sck)) |-> ##1 1'b1 ##0
    ($past(o_sck) == o_sck || st.div == 8'h00))
    else $error("serial clock phase shorter than one clock");

  a_div_reset: assert property (
    @(posedge i_core_clk)
    $rose(i_nrst) |-> st.div == DIV_RESET)
    else $error("divider not zero after reset");

  a_miso_enable: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    ($fell(i_nss_n) && !st.master && st.slv == S_IDLE &&
     $stable(st.master)) |-> ##[1:4] o_miso_oe)
    else $error("slave output not driven after select");

  a_miso_release: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    $rose(i_nss_n) |-> ##[1:4] !o_miso_oe)
    else $error("slave output not released after select");

  a_miso_cause: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (!st.master && $changed(o_miso) && !$changed(st.tx)) |->
    ($past(shift_ev) || $past(post_fire) || $past(nss_fall) ||
     $past(st.slv == S_ACTIVE && (rise || fall))))
    else $error("slave output changed without a shifting edge");

  a_last_edge: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st.slv == S_POST && $past(st.slv) == S_ACTIVE && !nss_rise)
    |-> ##3 (post_fire || st.slv == S_IDLE))
    else $error("phase one end wait has the wrong length");

  a_idle_level: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (st.mst == M_IDLE && $stable(st.mst)) |-> o_sck == st.cpol)
    else $error("idle clock level does not follow polarity");
endmodule : scg_top
`default_nettype wire

// ---- verification/scg_remote.sv ----
`default_nettype none
module scg_remote
  import scg_pkg::*;
(
  // Link-rate clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Frame request and mode
  input wire logic i_go,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic [7:0] i_byte,
  // Pins seen and driven
  input wire logic i_miso,
  input wire logic i_mosi_pin,
  output logic o_sck,
  output logic o_nss_n,
  output logic o_mosi,
  output logic o_miso,
  // Frame status
  output logic o_busy,
  output logic [7:0] o_got
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] ph;
  logic [4:0] e;
  logic [7:0] sh;
  // Remote slave answers the inverted master data
  assign o_miso = ~i_mosi_pin;
  // Ten ticks a phase: 300 ns, safely above five system clocks
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sck <= 1'b0;
      o_nss_n <= 1'b1;
      o_mosi <= 1'b0;
      o_busy <= 1'b0;
      o_got <= 8'h00;
      ph <= 4'h0;
      e <= 5'h00;
      sh <= 8'h00;
    end else if (!o_busy) begin
      o_sck <= i_cpol;
      o_nss_n <= 1'b1;
      // Released line must not look like held data
      o_mosi <= ~o_mosi;
      if (i_go) begin
        o_busy <= 1'b1;
        o_nss_n <= 1'b0;
        ph <= 4'h0;
        e <= 5'h00;
        o_mosi <= i_byte[7];
        sh <= i_cpha ? i_byte : {i_byte[6:0], 1'b0};
      end
    end else if (ph != 4'h9) begin
      ph <= ph + 4'h1;
    end else begin
      ph <= 4'h0;
      e <= e + 5'h01;
      if (e < 5'h10) begin
        o_sck <= ~o_sck;
        if (e[0] == i_cpha) begin
          o_got <= {o_got[6:0], i_miso};
        end else begin
          o_mosi <= sh[7];
          sh <= {sh[6:0], 1'b0};
        end
      end else if (e == 5'h11) begin
        o_nss_n <= 1'b1;
        o_busy <= 1'b0;
      end
    end
  end
endmodule : scg_remote
`default_nettype wire

// ---- verification/scg_top_tb.sv ----
`default_nettype none
module scg_top_tb
  import scg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic [7:0] pbyte = 8'h00;
  scg_apb_req_type req = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, sck, sck_oe, mosi, mosi_oe, miso, miso_oe;
  logic p_sck, p_nss_n, p_mosi, p_miso, p_busy;
  logic [7:0] p_got;
  logic sck_w, mosi_w, miso_w;
  int failures = 0;
  int n_compared = 0;
  // Clocks: remote side runs unrelated in phase
  always #25 clk = ~clk;
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  // Pin levels from whichever party drives
  assign sck_w = sck_oe ? sck : p_sck;
  assign mosi_w = mosi_oe ? mosi : p_mosi;
  assign miso_w = miso_oe ? miso : p_miso;
  scg_top u_scg_top (.i_core_clk(clk), .i_nrst(nrst), .i_link_sck(sck_w),
    .i_apb(req), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_sck(sck), .o_sck_oe(sck_oe), .o_mosi(mosi),
    .o_mosi_oe(mosi_oe), .i_mosi(mosi_w), .o_miso(miso),
    .o_miso_oe(miso_oe), .i_miso(miso_w), .i_nss_n(p_nss_n));
  scg_remote u_scg_remote (.i_clk(lclk), .i_nrst(nrst), .i_go(go),
    .i_cpol(cpol), .i_cpha(cpha), .i_byte(pbyte), .i_miso(miso_w),
    .i_mosi_pin(mosi_w), .o_sck(p_sck), .o_nss_n(p_nss_n),
    .o_mosi(p_mosi), .o_miso(p_miso), .o_busy(p_busy), .o_got(p_got));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask : chk_bit
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) failures++;
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb
  task automatic tally_and_finish();
    $display("Counts: %0d compared, %0d failures", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Master byte: first edge and every half period take div plus one
  task automatic master_run(input logic [7:0] dv, input logic pol,
                            input logic ph);
    int n;
    logic last;
    apb(1'b1, ADDR_DIV, {24'h0, dv});
    apb(1'b1, ADDR_CTRL, {29'h0, ph, pol, 1'b1});
    apb(1'b0, ADDR_DIV, 32'h0);
    chk(rd, {24'h0, dv}, "divider readback");
    chk_bit(sck, pol, "idle clock level");
    apb(1'b1, ADDR_DATA, 32'h5A);
    for (int k = 0; k < 16; k++) begin
      n = 0;
      last = sck;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (sck === last && n < 600);
      chk(32'(n), {24'h0, dv} + 32'h1, "half period");
    end
    repeat (4) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h2, "done without busy");
    apb(1'b1, ADDR_STATUS, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h0, "done cleared");
    if (dv == 8'h03) begin
      apb(1'b0, ADDR_DATA, 32'h0);
      chk(rd, 32'hA5, "echoed byte");
    end
    chk_bit(sck, pol, "clock back at idle");
    $display("test master div %0d cpol %0d cpha %0d done", dv, pol, ph);
  endtask : master_run
  // Slave byte exchanged with the remote master
  task automatic slave_run(input logic pol, input logic ph,
                           input logic [7:0] tx, input logic [7:0] rx);
    int n;
    n = 0;
    cpol <= pol;
    cpha <= ph;
    apb(1'b1, ADDR_CTRL, {29'h0, ph, pol, 1'b0});
    apb(1'b1, ADDR_DATA, {24'h0, tx});
    @(posedge lclk);
    pbyte <= rx;
    go <= 1'b1;
    @(posedge lclk);
    go <= 1'b0;
    do begin
      @(posedge lclk);
      n++;
    end while (p_busy !== 1'b0 && n < 1000);
    if (n >= 1000) failures++;
    repeat (12) @(posedge clk);
    chk({24'h0, p_got}, {24'h0, tx}, "byte seen by remote");
    apb(1'b0, ADDR_DATA, 32'h0);
    chk(rd, {24'h0, rx}, "byte received");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h2, "slave done");
    apb(1'b1, ADDR_STATUS, 32'h2);
    $display("test slave cpol %0d cpha %0d done", pol, ph);
  endtask : slave_run
  // Output must be driven soon after select falls
  always @(negedge p_nss_n) begin : sez_mon
    int n;
    n = 0;
    if (nrst === 1'b1) begin
      while (miso_oe !== 1'b1 && n < 6) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk_bit(n <= 4, 1'b1, "slave drive late");
    end
  end
  // Output must float soon after select rises
  always @(posedge p_nss_n) begin : sdz_mon
    int n;
    n = 0;
    if (nrst === 1'b1) begin
      while (miso_oe !== 1'b0 && n < 6) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk_bit(n <= 4, 1'b1, "slave release late");
    end
  end
  // Watchdog: whole run should need well under 1 ms
  initial begin
    #3_000_000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, ADDR_DIV, 32'h0);
    chk(rd, 32'h0, "divider reset value");
    chk_bit(sck_oe, 1'b0, "clock pin released");
    apb(1'b1, ADDR_DIV, 32'hA5);
    apb(1'b0, ADDR_DIV, 32'h0);
    chk(rd, 32'hA5, "divider read write");
    apb(1'b0, 12'h000, 32'h0);
    chk_bit(err, 1'b1, "unmapped flagged");
    chk(rd, 32'h0, "unmapped reads zero");
    $display("test registers done");
    master_run(8'h00, 1'b0, 1'b0);
    master_run(8'h01, 1'b1, 1'b1);
    master_run(8'h03, 1'b0, 1'b0);
    master_run(8'h03, 1'b1, 1'b1);
    master_run(8'hFF, 1'b1, 1'b0);
    for (int m = 0; m < 4; m++) begin
      slave_run(m[0], m[1], 8'h96 + 8'(m), 8'h4B + 8'(m));
    end
    tally_and_finish();
  end
endmodule : scg_top_tb
`default_nettype wire
